// [include/htb_pkg.sv]
/*
  Constants for the hold trigger routing link: word layout, route codes, register map.
  Assumes both ends and the bench import it and share one clock.
*/
package htb_pkg;
  localparam int CFG_W = 32;
  localparam int CHAN_W = 3;
  localparam int ROUTE_W = 4;
  localparam int EDGE_W = 8;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 8;

  // Configuration word field positions
  localparam int CFG_BUS_TO_OUT_BIT = 0;
  localparam int CFG_BUS0_OE_BIT = 1;
  localparam int CFG_MUX_OUT_BIT = 2;
  localparam int CFG_EDGE_MODE_BIT = 5;
  localparam int ROUTE_LSB = 8;
  localparam int CHAN_LSB = 20;
  localparam int EDGE_CNT_LSB = 24;
  localparam logic [CFG_W-1:0] CFG_RESET = 32'h0000_0000;

  // Trigger route codes
  localparam logic [ROUTE_W-1:0] ROUTE_NONE = 4'h0;
  localparam logic [ROUTE_W-1:0] ROUTE_PIN_TO_LINE = 4'h1;
  localparam logic [ROUTE_W-1:0] ROUTE_LINE_IN = 4'h2;
  localparam logic [ROUTE_W-1:0] ROUTE_LINE_IN_SCAN = 4'ha;
  localparam logic [ROUTE_W-1:0] ROUTE_LINE_TO_BOARD = 4'he;
  localparam logic [EDGE_W-1:0] EDGE_ONE = 8'h01;
  localparam logic [CHAN_W-1:0] CHAN_ONE = 3'h1;

  // Board register map (byte addresses)
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_CFG = 8'h04;
  localparam logic [ADDR_W-1:0] REG_SCAN_LOW = 8'h08;
  localparam logic [ADDR_W-1:0] REG_SCAN_HIGH = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_SAMPLE = 8'h10;
  localparam logic [ADDR_W-1:0] REG_TIMEBASE = 8'h14;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h18;
  localparam int CTRL_SCAN_EN_BIT = 0;
  localparam int CTRL_MAN_HOLD_BIT = 1;
  localparam int CTRL_DRIVE_BIT = 2;
  localparam int CTRL_LOAD_BIT = 3;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_HOLD_BIT = 1;
  localparam int STAT_PHASE_BIT = 2;

  localparam logic [CNT_W-1:0] COUNT_MIN = 16'h0002;
  localparam logic [CNT_W-1:0] COUNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] SCAN_RESET = 16'h0002;
  localparam logic [CNT_W-1:0] SAMPLE_RESET = 16'h0002;
  localparam logic [CNT_W-1:0] TIMEBASE_RESET = 16'h0000;
  localparam logic [CNT_W:0] SAMPLE_MAX = 17'h1_0000;
  localparam logic [CNT_W:0] SAMPLE_ONE = 17'h0_0001;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [4:0] LOAD_LAST = 5'h1f;
  localparam logic [4:0] LOAD_ONE = 5'h01;

  typedef enum logic [1:0] {
    HTB_LD_IDLE = 2'b00,
    HTB_LD_SHIFT = 2'b01,
    HTB_LD_DONE = 2'b11
  } htb_load_e;
endpackage

// [include/htb_link_if.sv]
/*
  Link between board end and module end; resolves the hold pin (pull-down)
  and line one (pull-up). Assumes every driver changes on the common clock.
*/
`timescale 1ns/100ps
interface htb_link_if;
  logic slot_select_n;
  logic cfg_shift;
  logic cfg_data;
  logic board_hold_o;
  logic board_hold_oe;
  logic dev_hold_o;
  logic dev_hold_oe;
  logic dev_line_o;
  logic dev_line_oe;
  logic ext_line_o;
  logic ext_line_oe;
  logic scan_sample_clock;
  logic scan_control_line;
  logic hold_trigger_pin;
  logic backplane_line_one;

  assign hold_trigger_pin = dev_hold_oe ? dev_hold_o : (board_hold_oe ? board_hold_o : 1'b0);
  assign backplane_line_one = dev_line_oe ? dev_line_o : (ext_line_oe ? ext_line_o : 1'b1);

  modport device (
    input slot_select_n, cfg_shift, cfg_data, hold_trigger_pin, backplane_line_one,
    input scan_sample_clock, scan_control_line,
    output dev_hold_o, dev_hold_oe, dev_line_o, dev_line_oe
  );
  modport board (
    input hold_trigger_pin,
    output slot_select_n, cfg_shift, cfg_data, board_hold_o, board_hold_oe, scan_sample_clock
  );
endinterface

// [rtl/htb_module_end.sv]
/*
  Conditioning module end: serial configuration word, bus drive and bus-to-output
  selection, hold trigger routing between pin, backplane line one and board, and the
  track/hold state in level or edge mode.
  Assumes link inputs are produced on aclk, so they are read without synchronisers.
*/
`timescale 1ns/100ps
// Behaviour
// - Bus0 enable clear means no bus drive
// - Low byte 00000011 feeds bus to output
// - Code 0001 sends inverted pin trigger out
// - Code 1110 forwards line one to board
// - Code 0000 forwards and drives nothing
// - Code 0010 takes trigger from line one
// - Code 0001 via other passes pin trigger
// - Host clears all bus drivers first
// - Other module routes trigger, never drives
// - Host holds before board samples output
// - Older board forces level mode only
// - Scan counter square wave, high spans scan
// - Scan low/high counts 2 to 65535
// - Sample interval 2-65536, zero means max
// - Host programs board, modules, then enables
// - Board scanning produces scan clock, trigger
// - External trigger pulses spaced for scan
// - Level mode tracks low, holds high
// - Edge mode holds, counts, select releases
// - Channel field picks starting channel
module htb_module_end #(
  parameter bit OLDER_BOARD = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  htb_link_if.device link,
  output logic bus0_drive,
  output logic bus_to_output,
  output logic output_ref_direct,
  output logic hold_active,
  output logic [htb_pkg::CHAN_W-1:0] mux_channel,
  output logic [htb_pkg::CFG_W-1:0] active_config
);
  import htb_pkg::*;

  logic [CFG_W-1:0] shift_word;
  logic select_q;
  logic latch_now;
  logic hold_src;
  logic hold_src_q;
  logic hold_rise;
  logic scan_ctl_q;
  logic scan_rise;
  logic sample_q;
  logic sample_rise;
  logic hold_edge;
  logic edge_mode;
  logic mux_mode;
  logic [ROUTE_W-1:0] route;
  logic [EDGE_W-1:0] edge_cnt;
  logic [EDGE_W-1:0] edge_target;
  logic [EDGE_W-1:0] edge_last;
  logic [CHAN_W-1:0] start_chan;

  assign route = active_config[ROUTE_LSB +: ROUTE_W];
  assign edge_target = active_config[EDGE_CNT_LSB +: EDGE_W];
  assign start_chan = active_config[CHAN_LSB +: CHAN_W];
  assign mux_mode = active_config[CFG_MUX_OUT_BIT];
  // A zero edge count still releases after one edge rather than never
  assign edge_last = (edge_target == '0) ? '0 : edge_target - EDGE_ONE;
  assign edge_mode = active_config[CFG_EDGE_MODE_BIT] & ~OLDER_BOARD;
  assign latch_now = ~select_q & link.slot_select_n;
  assign hold_rise = hold_src & ~hold_src_q;
  assign scan_rise = link.scan_control_line & ~scan_ctl_q;
  assign sample_rise = link.scan_sample_clock & ~sample_q;

  // Serial word is shifted MSB first while selected
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shift_word <= CFG_RESET;
    end else if (!link.slot_select_n && link.cfg_shift) begin
      shift_word <= {shift_word[CFG_W-2:0], link.cfg_data};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      select_q <= 1'b1;
    end else begin
      select_q <= link.slot_select_n;
    end
  end

  // Shadowed until deselect, so half a word never reaches the bus switches
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_config <= CFG_RESET;
    end else if (latch_now) begin
      active_config <= shift_word;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus0_drive <= 1'b0;
      bus_to_output <= 1'b0;
      output_ref_direct <= 1'b0;
    end else begin
      // The bus-to-output setting wins so the module never fights the bus it reads
      bus0_drive <= active_config[CFG_BUS0_OE_BIT] & ~active_config[CFG_BUS_TO_OUT_BIT];
      bus_to_output <= active_config[CFG_BUS_TO_OUT_BIT];
      output_ref_direct <= active_config[CFG_BUS_TO_OUT_BIT];
    end
  end

  // Line one carries the trigger inverted, so it is inverted back on the way in
  always_comb begin
    case (route)
      ROUTE_LINE_IN: begin
        hold_src = ~link.backplane_line_one;
      end
      ROUTE_LINE_IN_SCAN: begin
        hold_src = ~link.backplane_line_one;
      end
      ROUTE_LINE_TO_BOARD: begin
        hold_src = ~link.backplane_line_one;
      end
      default: begin
        hold_src = link.hold_trigger_pin;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.dev_line_oe <= 1'b0;
      link.dev_line_o <= 1'b1;
    end else begin
      link.dev_line_oe <= (route == ROUTE_PIN_TO_LINE);
      link.dev_line_o <= ~link.hold_trigger_pin;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.dev_hold_oe <= 1'b0;
      link.dev_hold_o <= 1'b0;
    end else begin
      link.dev_hold_oe <= (route == ROUTE_LINE_TO_BOARD);
      link.dev_hold_o <= ~link.backplane_line_one;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_src_q <= 1'b0;
      scan_ctl_q <= 1'b0;
      sample_q <= 1'b0;
    end else begin
      hold_src_q <= hold_src;
      scan_ctl_q <= link.scan_control_line;
      sample_q <= link.scan_sample_clock;
    end
  end

  // Edge mode: a second rising trigger while holding is ignored until release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_edge <= 1'b0;
      edge_cnt <= '0;
    end else if (!link.slot_select_n || !edge_mode) begin
      hold_edge <= 1'b0;
      edge_cnt <= '0;
    end else if (!hold_edge) begin
      edge_cnt <= '0;
      if (hold_rise) begin
        hold_edge <= 1'b1;
      end
    end else if (scan_rise) begin
      if (edge_cnt == edge_last) begin
        hold_edge <= 1'b0;
        edge_cnt <= '0;
      end else begin
        edge_cnt <= edge_cnt + EDGE_ONE;
      end
    end
  end

  // Reset value selects level mode, which is the power-up behaviour
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_active <= 1'b0;
    end else if (edge_mode) begin
      hold_active <= hold_edge;
    end else begin
      hold_active <= hold_src;
    end
  end

  // Multiplexed output steps one channel per sample while holding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mux_channel <= '0;
    end else if (!hold_active) begin
      mux_channel <= start_chan;
    end else if (mux_mode && sample_rise) begin
      mux_channel <= mux_channel + CHAN_ONE;
    end
  end
endmodule

// [rtl/htb_board_end.sv]
/*
  Board end: AXI4-Lite registers, config word loader, scan and sample counters.
  Assumes one clock; software sequences programming and bus clearing.
*/
`timescale 1ns/100ps
module htb_board_end (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [htb_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [htb_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  htb_link_if.board link
);
  import htb_pkg::*;

  logic aw_got;
  logic w_got;
  logic wr_en;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [31:0] wr_val;
  logic [31:0] rd_val;
  logic [31:0] wr_merged;
  logic scan_en;
  logic man_hold;
  logic drive_en;
  logic load_go;
  logic [CFG_W-1:0] cfg_word;
  logic [CNT_W-1:0] scan_low;
  logic [CNT_W-1:0] scan_high;
  logic [CNT_W-1:0] sample_int;
  logic [CNT_W-1:0] tb_div;
  logic [CNT_W-1:0] tb_cnt;
  logic tb_tick;
  logic phase_high;
  logic [CNT_W-1:0] phase_cnt;
  logic [CNT_W-1:0] phase_lim;
  logic [CNT_W:0] sample_cnt;
  logic [CNT_W:0] sample_lim;
  htb_load_e load_state;
  logic [4:0] load_idx;
  logic [CFG_W-1:0] load_shift;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [CNT_W-1:0] clamp(input logic [CNT_W-1:0] v);
    return (v < COUNT_MIN) ? COUNT_MIN : v;
  endfunction

  assign s_axi_awready = ~aw_got & ~s_axi_bvalid;
  assign s_axi_wready = ~w_got & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_en = aw_got & w_got;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else if (wr_en) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_en) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr <= REG_STATUS && aw_addr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  assign wr_val = wr_val_rd(aw_addr);
  assign wr_merged = merge(wr_val, w_data, w_strb);

  // Software must clear every bus driver before loading an indirect setting
  assign load_go = wr_en && aw_addr == REG_CTRL && w_strb[0] && w_data[CTRL_LOAD_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scan_en <= 1'b0;
      man_hold <= 1'b0;
      drive_en <= 1'b0;
      cfg_word <= CFG_RESET;
      scan_low <= SCAN_RESET;
      scan_high <= SCAN_RESET;
      sample_int <= SAMPLE_RESET;
      tb_div <= TIMEBASE_RESET;
    end else if (wr_en) begin
      case (aw_addr)
        REG_CTRL: begin
          scan_en <= wr_merged[CTRL_SCAN_EN_BIT];
          man_hold <= wr_merged[CTRL_MAN_HOLD_BIT];
          drive_en <= wr_merged[CTRL_DRIVE_BIT];
        end
        REG_CFG: cfg_word <= wr_merged;
        REG_SCAN_LOW: scan_low <= wr_merged[CNT_W-1:0];
        REG_SCAN_HIGH: scan_high <= wr_merged[CNT_W-1:0];
        REG_SAMPLE: sample_int <= wr_merged[CNT_W-1:0];
        REG_TIMEBASE: tb_div <= wr_merged[CNT_W-1:0];
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    case (s_axi_araddr)
      REG_STATUS: rd_val = {29'h0000_0000, phase_high, link.hold_trigger_pin,
                            load_state != HTB_LD_IDLE};
      default: rd_val = wr_val_rd(s_axi_araddr);
    endcase
  end

  function automatic logic [31:0] wr_val_rd(input logic [ADDR_W-1:0] a);
    case (a)
      REG_CTRL: return {29'h0000_0000, drive_en, man_hold, scan_en};
      REG_CFG: return cfg_word;
      REG_SCAN_LOW: return {16'h0000, scan_low};
      REG_SCAN_HIGH: return {16'h0000, scan_high};
      REG_SAMPLE: return {16'h0000, sample_int};
      REG_TIMEBASE: return {16'h0000, tb_div};
      default: return 32'h0000_0000;
    endcase
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= (s_axi_araddr <= REG_STATUS && s_axi_araddr[1:0] == 2'h0) ?
                     RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // A load asked for while busy is dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load_state <= HTB_LD_IDLE;
      load_idx <= '0;
      load_shift <= CFG_RESET;
      link.slot_select_n <= 1'b1;
      link.cfg_shift <= 1'b0;
      link.cfg_data <= 1'b0;
    end else begin
      case (load_state)
        HTB_LD_IDLE: begin
          if (load_go) begin
            load_shift <= cfg_word;
            load_idx <= '0;
            link.slot_select_n <= 1'b0;
            load_state <= HTB_LD_SHIFT;
          end
        end
        HTB_LD_SHIFT: begin
          link.cfg_shift <= 1'b1;
          link.cfg_data <= load_shift[CFG_W-1];
          load_shift <= {load_shift[CFG_W-2:0], 1'b0};
          load_idx <= load_idx + LOAD_ONE;
          if (load_idx == LOAD_LAST) begin
            load_state <= HTB_LD_DONE;
          end
        end
        HTB_LD_DONE: begin
          link.cfg_shift <= 1'b0;
          link.slot_select_n <= 1'b1;
          load_state <= HTB_LD_IDLE;
        end
        default: begin
          load_state <= HTB_LD_IDLE;
        end
      endcase
    end
  end

  // Scan enable restarts from a low phase
  assign tb_tick = scan_en && (tb_cnt == tb_div);
  assign phase_lim = phase_high ? clamp(scan_high) : clamp(scan_low);
  assign sample_lim = (sample_int == '0) ? SAMPLE_MAX : {1'b0, clamp(sample_int)};

  always_ff @(posedge aclk) begin
    if (!aresetn || !scan_en) begin
      tb_cnt <= '0;
      phase_high <= 1'b0;
      phase_cnt <= '0;
    end else begin
      tb_cnt <= tb_tick ? '0 : tb_cnt + COUNT_ONE;
      if (tb_tick) begin
        if (phase_cnt == phase_lim - COUNT_ONE) begin
          phase_high <= ~phase_high;
          phase_cnt <= '0;
        end else begin
          phase_cnt <= phase_cnt + COUNT_ONE;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !phase_high) begin
      sample_cnt <= '0;
      link.scan_sample_clock <= 1'b0;
    end else begin
      link.scan_sample_clock <= tb_tick && (sample_cnt == sample_lim - SAMPLE_ONE);
      if (tb_tick) begin
        sample_cnt <= (sample_cnt == sample_lim - SAMPLE_ONE) ? '0 : sample_cnt + SAMPLE_ONE;
      end
    end
  end

  // Without drive enable the counter output floats for an external trigger source
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.board_hold_o <= 1'b0;
      link.board_hold_oe <= 1'b0;
    end else begin
      link.board_hold_o <= scan_en ? phase_high : man_hold;
      link.board_hold_oe <= drive_en;
    end
  end
endmodule

// [verification/htb_link_checker.sv]
/*
  Link checker: bus drive, routing, hold mode, load framing.
  Assumes one clock; watches link and module end outputs.
*/
`timescale 1ns/100ps
module htb_link_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slot_select_n,
  input wire logic cfg_shift,
  input wire logic hold_trigger_pin,
  input wire logic backplane_line_one,
  input wire logic dev_hold_o,
  input wire logic dev_hold_oe,
  input wire logic dev_line_o,
  input wire logic dev_line_oe,
  input wire logic bus0_drive,
  input wire logic bus_to_output,
  input wire logic output_ref_direct,
  input wire logic hold_active,
  input wire logic [htb_pkg::CFG_W-1:0] active_config
);
  import htb_pkg::*;
  logic [5:0] shift_cnt;
  logic [CFG_W-1:0] prev_cfg;
  logic steady;
  logic level;
  logic [ROUTE_W-1:0] route;
  // Outputs lag the latched word by a cycle, so judge them once it has settled
  assign steady = prev_cfg == active_config;
  assign level = steady && !active_config[CFG_EDGE_MODE_BIT];
  assign route = active_config[ROUTE_LSB +: ROUTE_W];
  always_ff @(posedge aclk) begin
    prev_cfg <= active_config;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || slot_select_n) begin
      shift_cnt <= 6'h00;
    end else if (cfg_shift) begin
      shift_cnt <= shift_cnt + 6'h01;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  no_bus_drive_a: assert property (steady && !active_config[1] |-> !bus0_drive)
    else $error("bus zero driven with its enable clear");
  bus_read_a: assert property (steady && active_config[7:0] == 8'h03 |->
    bus_to_output && output_ref_direct && !bus0_drive) else $error("bus read setting wrong");
  pin_to_line_a: assert property (steady && route == ROUTE_PIN_TO_LINE |->
    dev_line_oe && dev_line_o == !$past(hold_trigger_pin)) else $error("line one copy wrong");
  line_to_board_a: assert property (steady && route == ROUTE_LINE_TO_BOARD |->
    dev_hold_oe && dev_hold_o == !$past(backplane_line_one)) else $error("board copy wrong");
  route_quiet_a: assert property (steady && route == ROUTE_NONE |->
    !dev_hold_oe && !dev_line_oe) else $error("quiet route drives a line");
  line_source_a: assert property (level && route == ROUTE_LINE_IN |->
    hold_active == !$past(backplane_line_one)) else $error("hold not from line one");
  level_follow_a: assert property (level && route == ROUTE_NONE |->
    hold_active == $past(hold_trigger_pin)) else $error("level hold does not follow pin");
  select_release_a: assert property ($fell(slot_select_n) && active_config[5] |->
    ##[1:3] !hold_active) else $error("select did not release hold");
  shift_frame_a: assert property (cfg_shift |-> !slot_select_n)
    else $error("shift outside a load frame");
  word_count_a: assert property ($rose(slot_select_n) |-> shift_cnt == 6'h20)
    else $error("load frame not a whole word");
  load_stable_a: assert property (!slot_select_n && !$past(slot_select_n) |->
    $stable(active_config)) else $error("setting changed during load");
  cover property (steady && route == ROUTE_PIN_TO_LINE && !backplane_line_one);
  cover property ($rose(slot_select_n));
  cover property ($rose(hold_active) && active_config[5]);
endmodule

// [verification/tb_top.sv]
/*
  Bench: both ends joined by the link; AXI4-Lite host tasks.
  Assumes 125 MHz; the bench plays the other module on line one.
*/
`timescale 1ns/100ps
module tb_top;
  import htb_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic bus0_drive, bus_to_output, output_ref_direct, hold_active;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, ctrl, w, d;
  logic [1:0] bresp, rresp, r;
  logic [CHAN_W-1:0] mux_channel;
  logic [CFG_W-1:0] active_config;
  logic [ROUTE_W-1:0] codes [5];
  logic [31:0] rst_val [7];
  int mismatches, check_count, lo, hi, dv, n;
  bit pin_src;
  htb_link_if link ();
  htb_board_end htb_board_end_i (
    .aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(link.board)
  );
  htb_module_end htb_module_end_i (
    .aclk, .aresetn, .link(link.device), .bus0_drive, .bus_to_output, .output_ref_direct,
    .hold_active, .mux_channel, .active_config
  );
  htb_link_checker htb_link_checker_i (
    .aclk, .aresetn, .slot_select_n(link.slot_select_n), .cfg_shift(link.cfg_shift),
    .hold_trigger_pin(link.hold_trigger_pin), .backplane_line_one(link.backplane_line_one),
    .dev_hold_o(link.dev_hold_o), .dev_hold_oe(link.dev_hold_oe), .dev_line_o(link.dev_line_o),
    .dev_line_oe(link.dev_line_oe), .bus0_drive, .bus_to_output, .output_ref_direct,
    .hold_active, .active_config
  );
  always #4 aclk = ~aclk;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge aclk);
  endtask
  task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [31:0] v,
                           input logic [1:0] er);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    chk("bresp", er, bresp);
  endtask
  task automatic axi_read(input logic [ADDR_W-1:0] a, output logic [31:0] v,
                          output logic [1:0] rr);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    rr = rresp;
  endtask
  task automatic set_ctrl(input logic [31:0] v);
    ctrl = v;
    axi_write(REG_CTRL, v, RESP_OKAY);
  endtask
  task automatic load_cfg(input logic [31:0] v);
    logic [31:0] s;
    logic [1:0] sr;
    axi_write(REG_CFG, v, RESP_OKAY);
    axi_write(REG_CTRL, ctrl | 32'h0000_0008, RESP_OKAY);
    do axi_read(REG_STATUS, s, sr); while (s[STAT_BUSY_BIT] !== 1'b0);
    tick(3);
    chk("active_config", v, active_config);
  endtask
  function automatic int phase_len(input int ticks, input int div);
    return (ticks < 2 ? 2 : ticks) * (div + 1);
  endfunction
  initial begin
    repeat (60000) @(posedge aclk);
    mismatches++;
    $display("FAIL watchdog expected done seen hang");
    close_out();
  end
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h05;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    ctrl = 32'h0000_0000;
    link.ext_line_o = 1'b1;
    link.ext_line_oe = 1'b0;
    link.scan_control_line = 1'b0;
    codes = '{ROUTE_NONE, ROUTE_PIN_TO_LINE, ROUTE_LINE_IN, ROUTE_LINE_IN_SCAN,
              ROUTE_LINE_TO_BOARD};
    rst_val = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0002, 32'h0000_0002,
                32'h0000_0002, 32'h0000_0000, 32'h0000_0000};
    void'($urandom(32'h0000_35d0));
    tick(20);
    aresetn <= 1'b1;
    tick(2);
    chk("hold_active", 1'b0, hold_active);
    for (int i = 0; i < 8; i++) begin
      axi_read(8'(4 * i), d, r);
      chk("rdata", i < 7 ? rst_val[i] : 32'h0000_0000, d);
      chk("rresp", i < 7 ? RESP_OKAY : RESP_SLVERR, r);
    end
    axi_write(8'h1c, 32'h0000_00ff, RESP_SLVERR);
    for (int i = 0; i < 6; i++) begin
      w = $urandom();
      if (i == 0) w[7:0] = 8'h03;
      if (i == 1) w[7:0] = 8'h02;
      load_cfg(w);
      chk("bus0_drive", w[1] & ~w[0], bus0_drive);
      chk("bus_to_output", {w[0], w[0]}, {bus_to_output, output_ref_direct});
      chk("mux_channel", w[22:20], mux_channel);
    end
    foreach (codes[k]) begin
      load_cfg({20'h0_0000, codes[k], codes[k] == ROUTE_LINE_IN ? 8'h02 : 8'h03});
      pin_src = codes[k] == ROUTE_NONE || codes[k] == ROUTE_PIN_TO_LINE;
      for (int t = 1; t >= 0; t--) begin
        // The board drives the pin, or the bench drives line one inverted
        set_ctrl(pin_src ? {29'h0, 1'b1, t[0], 1'b0} : 32'h0000_0000);
        link.ext_line_oe <= !pin_src;
        link.ext_line_o <= !t[0];
        tick(4);
        chk("hold_active", t, hold_active);
        if (codes[k] == ROUTE_PIN_TO_LINE) begin
          chk("line one", !t[0], link.backplane_line_one);
        end else if (codes[k] == ROUTE_LINE_TO_BOARD) begin
          chk("hold pin", t, link.hold_trigger_pin);
        end else begin
          chk("drives", 2'b00, {link.dev_hold_oe, link.dev_line_oe});
        end
      end
    end
    link.ext_line_oe <= 1'b0;
    load_cfg(32'h0200_0020);
    set_ctrl(32'h0000_0006);
    tick(4);
    set_ctrl(32'h0000_0004);
    tick(4);
    chk("edge hold", 1'b1, hold_active);
    for (int p = 0; p < 2; p++) begin
      link.scan_control_line <= 1'b1;
      tick(2);
      link.scan_control_line <= 1'b0;
      tick(3);
      chk("edge hold", p == 0, hold_active);
    end
    set_ctrl(32'h0000_0006);
    tick(4);
    set_ctrl(32'h0000_0004);
    load_cfg(32'h0200_0020);
    chk("select release", 1'b0, hold_active);
    for (int k = 0; k < 3; k++) begin
      lo = $urandom_range(9, 0);
      hi = $urandom_range(9, 0);
      dv = $urandom_range(2, 0);
      axi_write(REG_SCAN_LOW, lo, RESP_OKAY);
      axi_write(REG_SCAN_HIGH, hi, RESP_OKAY);
      axi_write(REG_TIMEBASE, dv, RESP_OKAY);
      set_ctrl(32'h0000_0005);
      while (link.hold_trigger_pin !== 1'b1) @(posedge aclk);
      n = 0;
      while (link.hold_trigger_pin === 1'b1) begin
        n++;
        @(posedge aclk);
      end
      chk("high phase", phase_len(hi, dv), n);
      n = 0;
      while (link.hold_trigger_pin === 1'b0) begin
        n++;
        @(posedge aclk);
      end
      chk("low phase", phase_len(lo, dv), n);
      set_ctrl(32'h0000_0000);
    end
    close_out();
  end
endmodule
